// *** lcr_pkg.sv ***
// Purpose: Shared constants for the LCD display-mode and power-save registers
// Assumes: 250 MHz core clock, byte addresses on an 8-bit register port
// Notes: Depth and rotation codes are the values written to display settings
package lcr_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_DISP = 8'h10;
    localparam logic [7:0] ADDR_PSAVE = 8'h14;
    localparam logic [7:0] ADDR_MAIN_START = 8'h48;
    localparam logic [7:0] ADDR_MAIN_OFFS = 8'h4C;
    localparam logic [7:0] ADDR_OV_START = 8'h50;
    localparam logic [7:0] ADDR_OV_OFFS = 8'h54;
    localparam logic [7:0] ADDR_OV_X = 8'h58;
    localparam logic [7:0] ADDR_OV_Y = 8'h5C;
    localparam logic [7:0] ADDR_INT_STAT = 8'h60;
    localparam logic [7:0] ADDR_INT_CLR = 8'h64;
    localparam logic [7:0] ADDR_INT_EN = 8'h68;
    localparam logic [7:0] ADDR_LUT_IDX = 8'h70;
    localparam logic [7:0] ADDR_LUT_DATA = 8'h74;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int DISP_INV_BIT = 20;
    localparam int DISP_OV_EN_BIT = 19;
    localparam int DISP_ROT_LSB = 16;
    localparam int DISP_DEPTH_LSB = 0;
    localparam int PS_VBLANK_BIT = 7;
    localparam int PS_MEMDOWN_BIT = 6;
    localparam int PS_EN_BIT = 4;
    localparam int WIN_LO_LSB = 0;
    localparam int WIN_HI_LSB = 16;
    localparam int INT_VBLANK = 0;
    localparam int INT_MEMDOWN = 1;
    localparam int INT_W = 2;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [31:0] DISP_RESET = 32'h0000_0000;
    localparam logic [31:0] PSAVE_RESET = 32'h0000_0010;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int PS_SETTLE_NS = 40;
    localparam int PS_SETTLE_CYC = (PS_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Codes and states
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        DEPTH_1 = 5'h01,
        DEPTH_2 = 5'h02,
        DEPTH_4 = 5'h04,
        DEPTH_8 = 5'h08,
        DEPTH_16 = 5'h10
    } lcr_depth_t;

    typedef enum logic [1:0] {
        ROT_0 = 2'h0,
        ROT_90 = 2'h1,
        ROT_180 = 2'h2,
        ROT_270 = 2'h3
    } lcr_rot_t;

    typedef enum logic [1:0] {
        MEM_UP = 2'h0,
        MEM_DOWN = 2'h1,
        MEM_WAKE = 2'h2
    } lcr_mem_state_t;

endpackage : lcr_pkg

// *** lcr_sticky_bit.sv ***
// Purpose: One sticky interrupt status bit with clear and enable
// Assumes: Clear is a one-cycle write pulse from the register port
// Notes: An event in the clear cycle keeps the bit set
`timescale 1ns/100ps
module lcr_sticky_bit (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Event and control
    input wire logic i_event,
    input wire logic i_clear,
    input wire logic i_enable,
    // Status
    output logic o_status,
    output logic o_pending
);

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_status <= 1'b0;
        end else if (i_event) begin
            o_status <= 1'b1;
        end else if (i_clear) begin
            o_status <= 1'b0;
        end
    end

    assign o_pending = o_status & i_enable;

endmodule : lcr_sticky_bit

// *** lcr_regs.sv ***
// Purpose: Display settings and power save registers with pixel and memory control
// Assumes: Pixel, timing and memory request inputs come from logic on i_clk
// Notes: Rules of operation below
`timescale 1ns/100ps
module lcr_regs #(
    parameter int ADDR_W = 18,
    parameter int OFFS_W = 11,
    parameter int POS_W = 10
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Register port
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wr_data,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rd_data,
    // Panel timing and pixel input
    input wire logic i_vert_blank,
    input wire logic i_pix_valid,
    input wire logic [15:0] i_pix_data,
    input wire logic [POS_W-1:0] i_pix_x,
    input wire logic [POS_W-1:0] i_pix_y,
    // Pixel output and fetch control
    output logic o_pix_valid,
    output logic [17:0] o_pix_data,
    output logic o_in_overlay,
    output logic [ADDR_W-1:0] o_fetch_base,
    output logic [OFFS_W-1:0] o_fetch_offset,
    output logic [1:0] o_rotation,
    output logic [4:0] o_depth,
    // Display buffer access
    input wire logic i_mem_req,
    output logic o_mem_enable,
    output logic o_mem_ack,
    // Interrupt
    output logic o_irq
);
    // ------------------------------------------------------------
    // Parameter checks and register storage
    // ------------------------------------------------------------
    if (ADDR_W < 1 || ADDR_W > 32 || OFFS_W < 1 || OFFS_W > 32) begin : g_chk_w
        $error("lcr_regs: address or offset width out of range");
    end
    if (POS_W < 1 || POS_W > 16) begin : g_chk_pos
        $error("lcr_regs: position width out of range");
    end
    localparam int INT_W_L = lcr_pkg::INT_W;
    logic [31:0] disp;
    logic ps_en;
    logic vblank;
    logic [ADDR_W-1:0] main_start;
    logic [OFFS_W-1:0] main_offs;
    logic [ADDR_W-1:0] ov_start;
    logic [OFFS_W-1:0] ov_offs;
    logic [POS_W-1:0] ov_x_lo;
    logic [POS_W-1:0] ov_x_hi;
    logic [POS_W-1:0] ov_y_lo;
    logic [POS_W-1:0] ov_y_hi;
    logic [INT_W_L-1:0] int_en;
    logic [7:0] lut_idx;
    logic [17:0] lut [0:255];
    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    wire wr_disp = i_wr && (i_addr == lcr_pkg::ADDR_DISP);
    wire wr_psave = i_wr && (i_addr == lcr_pkg::ADDR_PSAVE);
    wire wr_main_start = i_wr && (i_addr == lcr_pkg::ADDR_MAIN_START);
    wire wr_main_offs = i_wr && (i_addr == lcr_pkg::ADDR_MAIN_OFFS);
    wire wr_ov_start = i_wr && (i_addr == lcr_pkg::ADDR_OV_START);
    wire wr_ov_offs = i_wr && (i_addr == lcr_pkg::ADDR_OV_OFFS);
    wire wr_ov_x = i_wr && (i_addr == lcr_pkg::ADDR_OV_X);
    wire wr_ov_y = i_wr && (i_addr == lcr_pkg::ADDR_OV_Y);
    wire wr_int_clr = i_wr && (i_addr == lcr_pkg::ADDR_INT_CLR);
    wire wr_int_en = i_wr && (i_addr == lcr_pkg::ADDR_INT_EN);
    wire wr_lut_idx = i_wr && (i_addr == lcr_pkg::ADDR_LUT_IDX);
    wire wr_lut_data = i_wr && (i_addr == lcr_pkg::ADDR_LUT_DATA);
    // Only documented fields are writable; the rest read back zero
    wire [31:0] disp_mask = (32'h1 << lcr_pkg::DISP_INV_BIT)
        | (32'h1 << lcr_pkg::DISP_OV_EN_BIT)
        | (32'h3 << lcr_pkg::DISP_ROT_LSB)
        | (32'h1F << lcr_pkg::DISP_DEPTH_LSB);
    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            disp <= lcr_pkg::DISP_RESET;
        end else if (wr_disp) begin
            disp <= i_wr_data & disp_mask;
        end
    end
    // Reserved bit 0 is not stored, so a stray one is harmless
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ps_en <= lcr_pkg::PSAVE_RESET[lcr_pkg::PS_EN_BIT];
        end else if (wr_psave) begin
            ps_en <= i_wr_data[lcr_pkg::PS_EN_BIT];
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            main_start <= '0;
            main_offs <= '0;
            ov_start <= '0;
            ov_offs <= '0;
        end else begin
            if (wr_main_start) main_start <= i_wr_data[ADDR_W-1:0];
            if (wr_main_offs) main_offs <= i_wr_data[OFFS_W-1:0];
            if (wr_ov_start) ov_start <= i_wr_data[ADDR_W-1:0];
            if (wr_ov_offs) ov_offs <= i_wr_data[OFFS_W-1:0];
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ov_x_lo <= '0;
            ov_x_hi <= '0;
            ov_y_lo <= '0;
            ov_y_hi <= '0;
        end else begin
            if (wr_ov_x) begin
                ov_x_lo <= i_wr_data[lcr_pkg::WIN_LO_LSB +: POS_W];
                ov_x_hi <= i_wr_data[lcr_pkg::WIN_HI_LSB +: POS_W];
            end
            if (wr_ov_y) begin
                ov_y_lo <= i_wr_data[lcr_pkg::WIN_LO_LSB +: POS_W];
                ov_y_hi <= i_wr_data[lcr_pkg::WIN_HI_LSB +: POS_W];
            end
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            int_en <= '0;
            lut_idx <= 8'h00;
        end else begin
            if (wr_int_en) int_en <= i_wr_data[INT_W_L-1:0];
            if (wr_lut_idx) lut_idx <= i_wr_data[7:0];
        end
    end
    // Palette memory has no reset; software loads it before use
    always_ff @(posedge i_clk) begin
        if (wr_lut_data) begin
            lut[lut_idx] <= i_wr_data[17:0];
        end
    end
    // ------------------------------------------------------------
    // Pixel path: palette or bypass, invert, overlay select
    // ------------------------------------------------------------
    wire sw_invert = disp[lcr_pkg::DISP_INV_BIT];
    wire ov_en = disp[lcr_pkg::DISP_OV_EN_BIT];
    wire [4:0] depth = disp[lcr_pkg::DISP_DEPTH_LSB +: 5];
    // One rotation and depth feed both windows
    assign o_rotation = disp[lcr_pkg::DISP_ROT_LSB +: 2];
    assign o_depth = depth;
    wire is_16 = (depth == lcr_pkg::DEPTH_16);
    // Reserved depth codes fall back to a full 8-bit index
    wire [7:0] idx_mask = (depth == lcr_pkg::DEPTH_1) ? 8'h01 :
        (depth == lcr_pkg::DEPTH_2) ? 8'h03 :
        (depth == lcr_pkg::DEPTH_4) ? 8'h0F : 8'hFF;
    wire [7:0] pix_idx = i_pix_data[7:0] & idx_mask;
    wire [17:0] lut_out = lut[pix_idx];
    // 5-6-5 widened to 6-6-6 by repeating the top bit
    wire [17:0] expand = {i_pix_data[15:11], i_pix_data[15], i_pix_data[10:5],
        i_pix_data[4:0], i_pix_data[4]};
    wire [17:0] pix_colour = is_16 ? expand : lut_out;
    wire [17:0] next_pix_data = pix_colour ^ {18{sw_invert}};
    wire in_ov_x = (i_pix_x >= ov_x_lo) && (i_pix_x <= ov_x_hi);
    wire in_ov_y = (i_pix_y >= ov_y_lo) && (i_pix_y <= ov_y_hi);
    wire next_in_overlay = ov_en && in_ov_x && in_ov_y;
    wire [ADDR_W-1:0] next_fetch_base = next_in_overlay ? ov_start : main_start;
    wire [OFFS_W-1:0] next_fetch_offset = next_in_overlay ? ov_offs : main_offs;
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_pix_valid <= 1'b0;
            o_pix_data <= 18'h00000;
            o_in_overlay <= 1'b0;
            o_fetch_base <= '0;
            o_fetch_offset <= '0;
        end else begin
            o_pix_valid <= i_pix_valid;
            if (i_pix_valid) begin
                o_pix_data <= next_pix_data;
                o_in_overlay <= next_in_overlay;
                o_fetch_base <= next_fetch_base;
                o_fetch_offset <= next_fetch_offset;
            end
        end
    end
    // ------------------------------------------------------------
    // Memory controller power state
    // ------------------------------------------------------------
    lcr_pkg::lcr_mem_state_t mem_state;
    lcr_pkg::lcr_mem_state_t next_mem_state;
    logic [7:0] settle_cnt;
    localparam logic [7:0] SETTLE_LAST = 8'(lcr_pkg::PS_SETTLE_CYC - 1);
    wire settle_done = (settle_cnt == SETTLE_LAST);
    wire mem_down = (mem_state == lcr_pkg::MEM_DOWN);
    always_comb begin
        next_mem_state = mem_state;
        case (mem_state)
            lcr_pkg::MEM_UP: begin
                if (ps_en && !i_mem_req && settle_done) begin
                    next_mem_state = lcr_pkg::MEM_DOWN;
                end
            end
            lcr_pkg::MEM_DOWN: begin
                if (!ps_en) begin
                    next_mem_state = lcr_pkg::MEM_UP;
                end else if (i_mem_req) begin
                    next_mem_state = lcr_pkg::MEM_WAKE;
                end
            end
            lcr_pkg::MEM_WAKE: begin
                next_mem_state = ps_en ? lcr_pkg::MEM_DOWN : lcr_pkg::MEM_UP;
            end
            default: begin
                next_mem_state = lcr_pkg::MEM_UP;
            end
        endcase
    end
    // Requests in UP are acked next cycle; from DOWN one wake cycle later
    wire next_mem_ack = (mem_state == lcr_pkg::MEM_WAKE)
        || ((mem_state == lcr_pkg::MEM_UP) && i_mem_req);
    wire next_mem_enable = (next_mem_state != lcr_pkg::MEM_DOWN);
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            mem_state <= lcr_pkg::MEM_UP;
            settle_cnt <= 8'h00;
            o_mem_ack <= 1'b0;
            o_mem_enable <= 1'b1;
        end else begin
            mem_state <= next_mem_state;
            o_mem_ack <= next_mem_ack;
            o_mem_enable <= next_mem_enable;
            // Idle time counted so a burst of accesses does not thrash power
            if (mem_state != lcr_pkg::MEM_UP || !ps_en || i_mem_req) begin
                settle_cnt <= 8'h00;
            end else if (!settle_done) begin
                settle_cnt <= settle_cnt + 8'h01;
            end
        end
    end
    // ------------------------------------------------------------
    // Vertical non-display flag and interrupt status
    // ------------------------------------------------------------
    logic vblank_d;
    logic mem_down_d;
    logic [INT_W_L-1:0] int_stat;
    logic [INT_W_L-1:0] int_pend;
    wire [INT_W_L-1:0] int_event = {mem_down & ~mem_down_d, vblank & ~vblank_d};
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            vblank <= 1'b0;
            vblank_d <= 1'b0;
            mem_down_d <= 1'b0;
            o_irq <= 1'b0;
        end else begin
            vblank <= i_vert_blank;
            vblank_d <= vblank;
            mem_down_d <= mem_down;
            o_irq <= |int_pend;
        end
    end
    for (genvar g = 0; g < INT_W_L; g++) begin : g_int
        lcr_sticky_bit u_bit (
            .i_clk(i_clk),
            .i_rst(i_rst),
            .i_event(int_event[g]),
            .i_clear(wr_int_clr && i_wr_data[g]),
            .i_enable(int_en[g]),
            .o_status(int_stat[g]),
            .o_pending(int_pend[g])
        );
    end
    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    wire [31:0] psave_rd = ({31'h0, vblank} << lcr_pkg::PS_VBLANK_BIT)
        | ({31'h0, mem_down} << lcr_pkg::PS_MEMDOWN_BIT)
        | ({31'h0, ps_en} << lcr_pkg::PS_EN_BIT);
    wire [31:0] next_rd_data =
        (i_addr == lcr_pkg::ADDR_DISP) ? disp :
        (i_addr == lcr_pkg::ADDR_PSAVE) ? psave_rd :
        (i_addr == lcr_pkg::ADDR_MAIN_START) ? 32'(main_start) :
        (i_addr == lcr_pkg::ADDR_MAIN_OFFS) ? 32'(main_offs) :
        (i_addr == lcr_pkg::ADDR_OV_START) ? 32'(ov_start) :
        (i_addr == lcr_pkg::ADDR_OV_OFFS) ? 32'(ov_offs) :
        (i_addr == lcr_pkg::ADDR_OV_X) ? ((32'(ov_x_hi) << lcr_pkg::WIN_HI_LSB) | 32'(ov_x_lo)) :
        (i_addr == lcr_pkg::ADDR_OV_Y) ? ((32'(ov_y_hi) << lcr_pkg::WIN_HI_LSB) | 32'(ov_y_lo)) :
        (i_addr == lcr_pkg::ADDR_INT_STAT) ? 32'(int_stat) :
        (i_addr == lcr_pkg::ADDR_INT_EN) ? 32'(int_en) :
        (i_addr == lcr_pkg::ADDR_LUT_IDX) ? 32'(lut_idx) :
        (i_addr == lcr_pkg::ADDR_LUT_DATA) ? 32'(lut[lut_idx]) : 32'h0000_0000;
    // Read data stands only in the cycle after the strobe
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_rd_data <= 32'h0000_0000;
        end else begin
            o_rd_data <= i_rd ? next_rd_data : 32'h0000_0000;
        end
    end
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    invert_after_lut_a: assert property (
        i_pix_valid && !is_16 |=> o_pix_data == ($past(lut_out) ^ {18{$past(sw_invert)}}))
        else $error("palette pixel not inverted after lookup");
    invert_select_a: assert property (
        i_pix_valid && !sw_invert |=> o_pix_data == $past(pix_colour))
        else $error("pixel changed with invert clear");
    overlay_off_a: assert property (i_pix_valid && !ov_en |=> !o_in_overlay)
        else $error("overlay flagged while disabled");
    overlay_place_a: assert property (
        i_pix_valid && ov_en && in_ov_x && in_ov_y |=> o_in_overlay)
        else $error("pixel inside overlay not flagged");
    overlay_fetch_a: assert property (
        $rose(o_pix_valid) && o_in_overlay |-> o_fetch_base == $past(ov_start))
        else $error("overlay fetch base not own start");
    mode_write_a: assert property (
        wr_disp |=> o_rotation == $past(i_wr_data[17:16]) && o_depth == $past(i_wr_data[4:0]))
        else $error("rotation or depth not taken from write");
    bypass_16_a: assert property (
        i_pix_valid && is_16 |=> o_pix_data == ($past(expand) ^ {18{$past(sw_invert)}}))
        else $error("16 bpp pixel did not bypass palette");
    vblank_read_a: assert property (
        i_rd && i_addr == lcr_pkg::ADDR_PSAVE |=> o_rd_data[7] == $past(vblank))
        else $error("vertical blank status wrong on read");
    memdown_out_a: assert property (
        i_rd && i_addr == lcr_pkg::ADDR_PSAVE |=> o_rd_data[6] == !$past(o_mem_enable))
        else $error("memory down status disagrees with enable");
    ps_write_a: assert property (wr_psave |=> ps_en == $past(i_wr_data[4]))
        else $error("power save enable not written");
    ps_reset_a: assert property (
        @(posedge i_clk) disable iff (1'b0) $past(i_rst) |-> ps_en && mem_state == lcr_pkg::MEM_UP)
        else $error("power save enable not set by reset");
    wake_ack_a: assert property (
        mem_down && i_mem_req && ps_en |=> o_mem_enable ##1 o_mem_ack)
        else $error("access in power save not served");
    enter_down_c: cover property (mem_state == lcr_pkg::MEM_UP ##1 mem_down);
    wake_access_c: cover property (mem_down && i_mem_req ##2 o_mem_ack);
    overlay_pix_c: cover property (o_pix_valid && o_in_overlay);
    irq_raise_c: cover property (!o_irq ##1 o_irq);
endmodule : lcr_regs

// *** lcr_panel_model.sv ***
// Purpose: Panel stand-in: frame timing and pixel capture
// Assumes: At most one pixel per clock
// Notes: Blank is the last quarter of a 128-cycle frame
`timescale 1ns/100ps
module lcr_panel_model (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Pixels from the pipeline
    input wire logic i_pix_valid,
    input wire logic [17:0] i_pix_data,
    // Timing and capture
    output logic o_vert_blank,
    output logic [17:0] o_last_pix
);
    logic [6:0] line_cnt;
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            line_cnt <= 7'h00;
        end else begin
            line_cnt <= line_cnt + 7'h01;
        end
        if (i_pix_valid) begin
            o_last_pix <= i_pix_data;
        end
    end
    assign o_vert_blank = (line_cnt >= 7'h60);
endmodule : lcr_panel_model

// *** tb_top.sv ***
// Purpose: Self-checking bench for the display and power save registers
// Assumes: Design defaults ADDR_W=18, OFFS_W=11, POS_W=10
// Notes: Cycle counter cuts a hang short
`timescale 1ns/100ps
module tb_top;
    logic i_clk, i_rst, i_wr, i_rd, i_pix_valid, i_mem_req, vb;
    logic [7:0] i_addr;
    logic [31:0] i_wr_data, o_rd_data;
    logic [15:0] i_pix_data;
    logic [9:0] i_pix_x, i_pix_y;
    logic o_pix_valid, o_in_overlay, o_mem_enable, o_mem_ack, o_irq;
    logic [17:0] o_pix_data, o_fetch_base, last_pix;
    logic [10:0] o_fetch_offset;
    logic [1:0] o_rotation;
    logic [4:0] o_depth;
    int n_errors = 0;
    int tests_run = 0;
    int cyc = 0;
    logic [31:0] rw[6] = '{32'h1, 32'h10002, 32'h20004, 32'h30008, 32'h180010, 32'hFF04FF00};
    logic [31:0] rr[6] = '{32'h1, 32'h10002, 32'h20004, 32'h30008, 32'h180010, 32'h0};
    lcr_regs lcr_regs_inst (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
        .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data),
        .i_vert_blank(vb), .i_pix_valid(i_pix_valid), .i_pix_data(i_pix_data),
        .i_pix_x(i_pix_x), .i_pix_y(i_pix_y), .o_pix_valid(o_pix_valid),
        .o_pix_data(o_pix_data), .o_in_overlay(o_in_overlay), .o_fetch_base(o_fetch_base),
        .o_fetch_offset(o_fetch_offset), .o_rotation(o_rotation), .o_depth(o_depth),
        .i_mem_req(i_mem_req), .o_mem_enable(o_mem_enable), .o_mem_ack(o_mem_ack),
        .o_irq(o_irq));
    lcr_panel_model lcr_panel_model_inst (.i_clk(i_clk), .i_rst(i_rst),
        .i_pix_valid(o_pix_valid), .i_pix_data(o_pix_data), .o_vert_blank(vb),
        .o_last_pix(last_pix));
    // ------------------------------------------------------------
    // Clock, timeout and tasks
    // ------------------------------------------------------------
    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_errors++;
            finish_test();
        end
    end
    task finish_test;
        $display("tests_run %0d n_errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finish_test
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wr_data <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 chk($sformatf("read %h", a), e, o_rd_data);
    endtask : rd
    task px(input logic [15:0] d, input logic [9:0] x, input logic [31:0] ep,
            input logic [31:0] eo, input logic [31:0] eb, input logic [31:0] ef);
        @(posedge i_clk);
        i_pix_valid <= 1'b1;
        i_pix_data <= d;
        i_pix_x <= x;
        i_pix_y <= 10'hF;
        @(posedge i_clk);
        i_pix_valid <= 1'b0;
        #1 chk("pixel", ep, 32'(o_pix_data));
        chk("pix_valid", 32'h1, 32'(o_pix_valid));
        chk("overlay", eo, 32'(o_in_overlay));
        chk("base", eb, 32'(o_fetch_base));
        chk("offset", ef, 32'(o_fetch_offset));
        @(posedge i_clk);
        #1 chk("panel", ep, 32'(last_pix));
        chk("pix_valid", 32'h0, 32'(o_pix_valid));
    endtask : px
    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        {i_rst, i_wr, i_rd, i_pix_valid, i_mem_req} = 5'h10;
        {i_addr, i_wr_data, i_pix_data, i_pix_x, i_pix_y} = '0;
        repeat (5) @(posedge i_clk);
        i_rst <= 1'b0;
        rd(lcr_pkg::ADDR_DISP, lcr_pkg::DISP_RESET);
        rd(lcr_pkg::ADDR_PSAVE, 32'h10);
        wr(lcr_pkg::ADDR_INT_EN, 32'h2);
        for (int i = 0; i < 6; i++) begin
            wr(lcr_pkg::ADDR_DISP, rw[i]);
            rd(lcr_pkg::ADDR_DISP, rr[i]);
            chk("rotation", 32'(rr[i][17:16]), 32'(o_rotation));
            chk("depth", 32'(rr[i][4:0]), 32'(o_depth));
        end
        $display("test registers done");
        chk("irq", 32'h1, 32'(o_irq));
        rd(lcr_pkg::ADDR_PSAVE, 32'h50);
        rd(lcr_pkg::ADDR_INT_STAT, 32'h2);
        @(posedge i_clk);
        i_mem_req <= 1'b1;
        @(posedge i_clk);
        i_mem_req <= 1'b0;
        #1 chk("mem_enable", 32'h1, 32'(o_mem_enable));
        @(posedge i_clk);
        #1 chk("mem_ack", 32'h1, 32'(o_mem_ack));
        chk("mem_enable", 32'h0, 32'(o_mem_enable));
        wr(lcr_pkg::ADDR_PSAVE, 32'h0);
        wr(lcr_pkg::ADDR_INT_EN, 32'h0);
        wr(lcr_pkg::ADDR_INT_CLR, 32'h3);
        rd(lcr_pkg::ADDR_PSAVE, 32'h0);
        rd(lcr_pkg::ADDR_INT_STAT, 32'h0);
        chk("irq", 32'h0, 32'(o_irq));
        wr(8'h7C, 32'hFFFFFFFF);
        rd(8'h7C, 32'h0);
        while (!vb) @(posedge i_clk);
        repeat (3) @(posedge i_clk);
        rd(lcr_pkg::ADDR_PSAVE, 32'h80);
        rd(lcr_pkg::ADDR_INT_STAT, 32'h1);
        while (vb) @(posedge i_clk);
        repeat (3) @(posedge i_clk);
        rd(lcr_pkg::ADDR_PSAVE, 32'h0);
        $display("test power save done");
        wr(lcr_pkg::ADDR_OV_X, 32'h14000A);
        wr(lcr_pkg::ADDR_OV_Y, 32'h14000A);
        wr(lcr_pkg::ADDR_OV_START, 32'h100);
        wr(lcr_pkg::ADDR_OV_OFFS, 32'h20);
        wr(lcr_pkg::ADDR_MAIN_START, 32'h200);
        wr(lcr_pkg::ADDR_MAIN_OFFS, 32'h40);
        wr(lcr_pkg::ADDR_DISP, 32'h180010);
        px(16'hF800, 10'd15, 32'hFFF, 32'h1, 32'h100, 32'h20);
        px(16'h1F, 10'd30, 32'h3FFC0, 32'h0, 32'h200, 32'h40);
        wr(lcr_pkg::ADDR_DISP, 32'h8);
        wr(lcr_pkg::ADDR_LUT_IDX, 32'h5);
        wr(lcr_pkg::ADDR_LUT_DATA, 32'h12345);
        px(16'h105, 10'd15, 32'h12345, 32'h0, 32'h200, 32'h40);
        wr(lcr_pkg::ADDR_DISP, 32'h180008);
        px(16'h105, 10'd15, 32'h2DCBA, 32'h1, 32'h100, 32'h20);
        $display("test pixels done");
        finish_test();
    end
endmodule : tb_top
